// ===== shared/pwm_regs.svh
/*
 * constants of the paired word memory board: sizes, field positions,
 * timing figures and cycle counts.
 * assumes a 100 MHz core clock; included by the package and the rtl.
 */
`ifndef PWM_REGS_SVH
`define PWM_REGS_SVH

// ***************************************************************
// sizes and field positions
// ***************************************************************
`define PWM_ADDR_W 20
`define PWM_DATA_W 48
`define PWM_WORD_W 24
`define PWM_CHK_W 5
`define PWM_STORE_W 58
`define PWM_PAIRS 32768
`define PWM_EVEN_D_HI 57
`define PWM_EVEN_D_LO 34
`define PWM_EVEN_C_LO 29
`define PWM_ODD_D_LO 5
`define PWM_OE_DBL 2'b00
`define PWM_OE_SGL 2'b10
`define PWM_OE_OFF 2'b11

// ***************************************************************
// timing
// ***************************************************************
`define PWM_CLK_NS 10
`define PWM_SEMI_CYC_NS 400
`define PWM_SEMI_ACC_NS 290
`define PWM_FAST_NS 45
`define PWM_CORE_CYC_NS 500
`define PWM_CORE_ACC_NS 240
// least times round up, the fast limit rounds down
`define PWM_SEMI_CYC ((`PWM_SEMI_CYC_NS + `PWM_CLK_NS - 1) / `PWM_CLK_NS)
`define PWM_SEMI_ACC ((`PWM_SEMI_ACC_NS + `PWM_CLK_NS - 1) / `PWM_CLK_NS)
`define PWM_CORE_CYC ((`PWM_CORE_CYC_NS + `PWM_CLK_NS - 1) / `PWM_CLK_NS)
`define PWM_CORE_ACC ((`PWM_CORE_ACC_NS + `PWM_CLK_NS - 1) / `PWM_CLK_NS)
`define PWM_FAST_CYC (`PWM_FAST_NS / `PWM_CLK_NS)

`endif

// ===== shared/pwm_pkg.sv
/*
 * types of the paired word memory board.
 * assumes pwm_regs.svh on the include path.
 */
`include "pwm_regs.svh"

package pwm_pkg;
   // one bus request as sampled from the backplane
   typedef struct packed {
      logic req;
      logic wr;
      logic dbl;
      logic [`PWM_ADDR_W-1:0] addr;
      logic [`PWM_DATA_W-1:0] wdata;
   } pwm_req_t;

   // power supervisor levels
   typedef struct packed {
      logic fail;
      logic backup;
   } pwm_pwr_t;

   // cycle sequencer, gray along idle-access-hold-release
   typedef enum logic [1:0] {
      PWM_IDLE = 2'b00,
      PWM_ACC = 2'b01,
      PWM_HOLD = 2'b11,
      PWM_REL = 2'b10
   } pwm_state_t;
endpackage : pwm_pkg

// ===== rtl/pwm_paired_word_memory.sv
/*
 * paired word memory board front end: bus handshake, pair storage
 * with check bits, pair buffer fast access, power fail refresh mode.
 * assumes a four-phase requester: req held with address and data
 * until ack rises, then dropped; all backplane inputs are async.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.svh"

module pwm_paired_word_memory import pwm_pkg::*; #(
   parameter logic [4:0] BOARD_BASE = 5'h00, // slot in the address space
   parameter bit CORE_MODE = 1'b0,           // parity core board timing
   parameter int unsigned REFRESH_CYC = 1560, // cycles between refreshes
   parameter int unsigned SEC_CYC = 100000000, // cycles per second
   parameter int unsigned HOLD_SEC = 3600    // backup hold time in s
) (
   // clock and reset
   input wire logic core_clk,
   input wire logic rst,
   // backplane request and data
   input wire logic bus_req,
   input wire logic bus_wr,
   input wire logic bus_dbl,
   input wire logic [`PWM_ADDR_W-1:0] bus_addr,
   input wire logic [`PWM_DATA_W-1:0] dbus_in,
   // backplane answer
   output logic [`PWM_DATA_W-1:0] dbus_out,
   output logic [1:0] dbus_oe_n,
   output logic bus_ack,
   output logic parity_err,
   output logic busy,
   // power supervisor
   input wire logic pwr_fail,
   input wire logic backup_present,
   output logic refresh_mode,
   output logic refresh_tick,
   output logic data_lost
);

   // ***************************************************************
   // check bit functions
   // ***************************************************************

   // hamming check bits over positions 3..29, powers of two skipped
   function automatic logic [4:0] ham_gen(input logic [23:0] d);
      logic [4:0] c;
      logic [4:0] p;
      c = 5'h00;
      p = 5'h03;
      for (int i = 0; i < 24; i++) begin
         if (p == 5'h04 || p == 5'h08 || p == 5'h10) begin
            p = p + 5'h01;
         end
         if (d[i]) begin
            c = c ^ p;
         end
         p = p + 5'h01;
      end
      return c;
   endfunction : ham_gen

   // stored check field: hamming or one odd parity bit
   function automatic logic [4:0] chk_gen(input logic [23:0] d);
      return CORE_MODE ? {4'h0, ~^d} : ham_gen(d);
   endfunction : chk_gen

   // check one word: {error, corrected data}
   function automatic logic [24:0] chk_fix(input logic [23:0] d,
                                           input logic [4:0] c);
      logic [4:0] s;
      logic [4:0] p;
      logic [23:0] f;
      s = ham_gen(d) ^ c;
      p = 5'h03;
      f = d;
      if (CORE_MODE) begin
         return {~^{d, c[0]}, d};
      end
      for (int i = 0; i < 24; i++) begin
         if (p == 5'h04 || p == 5'h08 || p == 5'h10) begin
            p = p + 5'h01;
         end
         if (p == s) begin
            f[i] = ~d[i];
         end
         p = p + 5'h01;
      end
      return {s != 5'h00, f};
   endfunction : chk_fix

   // ***************************************************************
   // input synchronisers
   // ***************************************************************
   pwm_req_t req_raw; // backplane pins bundled
   pwm_req_t req_m_r; // first stage
   pwm_req_t req_s; // second stage, the only one logic reads
   pwm_pwr_t pwr_m_r;
   pwm_pwr_t pwr_s;

   assign req_raw = {bus_req, bus_wr, bus_dbl, bus_addr, dbus_in};

   // two flops on every async pin
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         req_m_r <= '0;
         req_s <= '0;
         pwr_m_r <= '0;
         pwr_s <= '0;
      end else begin
         req_m_r <= req_raw;
         req_s <= req_m_r;
         pwr_m_r <= {pwr_fail, backup_present};
         pwr_s <= pwr_m_r;
      end
   end

   // ***************************************************************
   // storage and pair buffer
   // ***************************************************************
   // pair: even data, even check, odd data, odd check
   logic [`PWM_STORE_W-1:0] mem [0:`PWM_PAIRS-1];
   logic [`PWM_STORE_W-1:0] mem_q_r; // pair read at cycle start
   logic [47:0] pair_buf_r; // last pair, even word high
   logic [18:0] last_pair_r; // pair address of last access
   logic buf_valid_r; // buffer holds a live pair
   logic [1:0] pair_err_r; // errors seen when buffer loaded
   pwm_req_t txn_r; // request being served
   logic fast_r; // served from the buffer
   pwm_state_t st_r;
   pwm_state_t st_nxt;
   logic [6:0] cnt_r; // cycles since start, saturating

   // ***************************************************************
   // decode
   // ***************************************************************
   wire logic sel_hit; // address falls on this board
   wire logic hit; // repeat of the buffered pair
   wire logic start; // request accepted this cycle
   wire logic [24:0] fix_e;
   wire logic [24:0] fix_o;
   wire logic [23:0] new_e; // even word to store
   wire logic [23:0] new_o; // odd word to store
   wire logic [47:0] src_pair; // pair answered from
   wire logic [1:0] src_err;
   wire logic [23:0] src_word; // addressed word of a single read
   wire logic word_err; // error of the addressed word
   wire logic do_wb; // write the pair back
   wire logic [6:0] acc_tgt;
   wire logic [6:0] cyc_tgt;

   assign sel_hit = CORE_MODE ? (req_s.addr[19:15] == BOARD_BASE)
                              : (req_s.addr[19:16] == BOARD_BASE[4:1]);
   assign hit = buf_valid_r && !req_s.wr
                && req_s.addr[19:1] == last_pair_r;
   assign start = st_r == PWM_IDLE && req_s.req && sel_hit
                  && !refresh_mode;

   assign fix_e = chk_fix(mem_q_r[`PWM_EVEN_D_HI:`PWM_EVEN_D_LO],
                          mem_q_r[`PWM_EVEN_D_LO-1:`PWM_EVEN_C_LO]);
   assign fix_o = chk_fix(mem_q_r[`PWM_EVEN_C_LO-1:`PWM_ODD_D_LO],
                          mem_q_r[`PWM_ODD_D_LO-1:0]);
   // addressed word replaced, partner kept
   assign new_e = !txn_r.wr ? fix_e[23:0]
                : txn_r.dbl ? txn_r.wdata[47:24]
                : txn_r.addr[0] ? fix_e[23:0] : txn_r.wdata[23:0];
   assign new_o = !txn_r.wr ? fix_o[23:0]
                : txn_r.dbl ? txn_r.wdata[23:0]
                : txn_r.addr[0] ? txn_r.wdata[23:0] : fix_o[23:0];
   assign do_wb = txn_r.wr || CORE_MODE || fix_e[24] || fix_o[24];

   // buffered answer carries its old flags, no new check
   assign src_pair = fast_r ? pair_buf_r : {new_e, new_o};
   assign src_err = fast_r ? pair_err_r : {fix_e[24], fix_o[24]};
   assign src_word = txn_r.addr[0] ? src_pair[23:0] : src_pair[47:24];
   assign word_err = txn_r.addr[0] ? src_err[0] : src_err[1];

   assign acc_tgt = fast_r ? 7'(`PWM_FAST_CYC)
                  : CORE_MODE ? 7'(`PWM_CORE_ACC) : 7'(`PWM_SEMI_ACC);
   assign cyc_tgt = fast_r ? 7'(`PWM_FAST_CYC)
                  : CORE_MODE ? 7'(`PWM_CORE_CYC) : 7'(`PWM_SEMI_CYC);

   // ***************************************************************
   // cycle sequencer
   // ***************************************************************
   always_comb begin
      st_nxt = st_r;
      unique case (st_r)
         PWM_IDLE: if (start) st_nxt = PWM_ACC;
         PWM_ACC: if (cnt_r >= acc_tgt) st_nxt = PWM_HOLD;
         PWM_HOLD: if (!req_s.req) st_nxt = PWM_REL;
         PWM_REL: if (cnt_r >= cyc_tgt) st_nxt = PWM_IDLE;
      endcase
   end

   // state, counter and request capture
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         st_r <= PWM_IDLE;
         cnt_r <= 7'h00;
         txn_r <= '0;
         fast_r <= 1'b0;
      end else begin
         st_r <= st_nxt;
         cnt_r <= start ? 7'h01 : (cnt_r == 7'h7f ? cnt_r : cnt_r + 7'h01);
         if (start) begin
            txn_r <= req_s;
            fast_r <= hit;
         end
      end
   end

   // storage read at start, write back at access end
   always_ff @(posedge core_clk) begin
      if (start) begin
         mem_q_r <= mem[req_s.addr[15:1]];
      end
      if (st_r == PWM_ACC && st_nxt == PWM_HOLD && !fast_r && do_wb) begin
         mem[txn_r.addr[15:1]] <= {new_e, chk_gen(new_e),
                                   new_o, chk_gen(new_o)};
      end
   end

   // pair buffer and last address, reloaded by every memory access until data_lost, which invalidates it
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         pair_buf_r <= 48'h0;
         last_pair_r <= 19'h0;
         buf_valid_r <= 1'b0;
         pair_err_r <= 2'b00;
      end else if (data_lost) begin
         buf_valid_r <= 1'b0;
      end else if (st_r == PWM_ACC && st_nxt == PWM_HOLD && !fast_r) begin
         pair_buf_r <= {new_e, new_o};
         last_pair_r <= txn_r.addr[19:1];
         buf_valid_r <= 1'b1;
         pair_err_r <= txn_r.wr ? 2'b00 : {fix_e[24], fix_o[24]};
      end
   end

   // ***************************************************************
   // bus answer
   // ***************************************************************
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         bus_ack <= 1'b0;
         dbus_out <= 48'h0;
         dbus_oe_n <= `PWM_OE_OFF;
         parity_err <= 1'b0;
         busy <= 1'b0;
      end else begin
         busy <= st_nxt != PWM_IDLE;
         if (st_r == PWM_ACC && st_nxt == PWM_HOLD) begin
            bus_ack <= 1'b1;
            if (txn_r.wr) begin
               dbus_oe_n <= `PWM_OE_OFF;
               parity_err <= 1'b0;
            end else if (txn_r.dbl) begin
               dbus_out <= src_pair;
               dbus_oe_n <= `PWM_OE_DBL;
               parity_err <= |src_err;
            end else begin
               dbus_out <= {24'h0, src_word};
               dbus_oe_n <= `PWM_OE_SGL;
               parity_err <= word_err;
            end
         end else if (st_nxt != PWM_HOLD) begin
            bus_ack <= 1'b0;
            dbus_oe_n <= `PWM_OE_OFF;
            parity_err <= 1'b0;
         end
      end
   end

   // ***************************************************************
   // power fail refresh mode
   // ***************************************************************
   logic [31:0] ref_cnt_r; // cycles since last refresh
   logic [31:0] sec_cnt_r; // cycles within the second
   logic [31:0] hold_cnt_r; // seconds spent on backup

   // enter on fail with backup once idle, leave on power return
   always_ff @(posedge core_clk or posedge rst) begin
      if (rst) begin
         refresh_mode <= 1'b0;
         refresh_tick <= 1'b0;
         data_lost <= 1'b0;
         ref_cnt_r <= 32'h0;
         sec_cnt_r <= 32'h0;
         hold_cnt_r <= 32'h0;
      end else begin
         refresh_tick <= 1'b0;
         if (!pwr_s.fail) begin
            refresh_mode <= 1'b0;
            ref_cnt_r <= 32'h0;
            sec_cnt_r <= 32'h0;
            hold_cnt_r <= 32'h0;
         end else if (!pwr_s.backup && !refresh_mode) begin
            data_lost <= 1'b1; // no backup, contents gone
         end else if (!refresh_mode) begin
            refresh_mode <= st_r == PWM_IDLE;
         end else if (hold_cnt_r >= HOLD_SEC || !pwr_s.backup) begin
            data_lost <= 1'b1;
         end else begin
            ref_cnt_r <= ref_cnt_r + 32'h1;
            if (ref_cnt_r >= REFRESH_CYC - 1) begin
               ref_cnt_r <= 32'h0;
               refresh_tick <= 1'b1;
            end
            sec_cnt_r <= sec_cnt_r + 32'h1;
            if (sec_cnt_r >= SEC_CYC - 1) begin
               sec_cnt_r <= 32'h0;
               hold_cnt_r <= hold_cnt_r + 32'h1;
            end
         end
      end
   end

   // ***************************************************************
   // assertions
   // ***************************************************************
   sequence s_fast_start;
      st_r == PWM_IDLE && start && hit;
   endsequence
   sequence s_semi_start;
      st_r == PWM_IDLE && start && !hit && !CORE_MODE;
   endsequence

   fast_ack_time_a: assert property (@(posedge core_clk) disable iff (rst)
      s_fast_start |-> ##1 (!bus_ack)[*4] ##1 bus_ack)
      else $error("fast access ack not at four cycles");
   semi_ack_time_a: assert property (@(posedge core_clk) disable iff (rst)
      s_semi_start |-> ##29 !bus_ack ##1 bus_ack)
      else $error("memory access ack not at 29 cycles");
   semi_cycle_len_a: assert property (@(posedge core_clk) disable iff (rst)
      (st_r == PWM_IDLE && $past(st_r) == PWM_REL && !fast_r && !CORE_MODE)
      |-> $past(cnt_r) >= 7'd40)
      else $error("memory cycle shorter than 40 cycles");
   ack_held_a: assert property (@(posedge core_clk) disable iff (rst)
      bus_ack && req_s.req |=> bus_ack && st_r == PWM_HOLD)
      else $error("ack dropped while request still high");
   single_lanes_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(bus_ack) && !txn_r.wr && !txn_r.dbl
      |-> dbus_oe_n == 2'b10 && dbus_out[47:24] == 24'h0)
      else $error("single read drives wrong lanes");
   double_lanes_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(bus_ack) && !txn_r.wr && txn_r.dbl |-> dbus_oe_n == 2'b00)
      else $error("double read not on all lanes");
   write_quiet_a: assert property (@(posedge core_clk) disable iff (rst)
      bus_ack && txn_r.wr |-> dbus_oe_n == 2'b11 && !parity_err)
      else $error("write drives data or error");
   buf_reload_a: assert property (@(posedge core_clk) disable iff (rst)
      $rose(bus_ack) && !fast_r && !data_lost
      |-> buf_valid_r && last_pair_r == txn_r.addr[19:1])
      else $error("pair buffer not reloaded by access");
   refresh_block_a: assert property (@(posedge core_clk) disable iff (rst)
      refresh_mode && st_r == PWM_IDLE |=> st_r == PWM_IDLE)
      else $error("request served in refresh mode");
   refresh_enter_a: assert property (@(posedge core_clk) disable iff (rst)
      pwr_s.fail && pwr_s.backup && st_r == PWM_IDLE && !data_lost
      |=> refresh_mode)
      else $error("refresh mode not entered on power fail");

endmodule : pwm_paired_word_memory
`default_nettype wire

// ===== dv/pwm_bus_master.sv
/*
 * bus master model standing for the processor and block channels.
 * assumes pwm_pkg and pwm_regs.svh; the bench calls xfer by hierarchy.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.svh"

module pwm_bus_master import pwm_pkg::*; (
   // clock
   input wire logic core_clk,
   // request lines toward the board
   output logic bus_req,
   output logic bus_wr,
   output logic bus_dbl,
   output logic [`PWM_ADDR_W-1:0] bus_addr,
   output logic [`PWM_DATA_W-1:0] dbus_in,
   // answer lines from the board
   input wire logic [`PWM_DATA_W-1:0] dbus_out,
   input wire logic [1:0] dbus_oe_n,
   input wire logic bus_ack,
   input wire logic parity_err
);
   // ***************************************************************
   // request carrier
   // ***************************************************************
   pwm_req_t q = '0; // held request
   wire logic [`PWM_DATA_W-1:0] view; // what the master sees on the bus
   assign bus_req = q.req;
   assign bus_wr = q.wr;
   assign bus_dbl = q.dbl;
   assign bus_addr = q.addr;
   assign dbus_in = q.wdata;
   // lanes not enabled show the inverse of the last value
   assign view = {dbus_oe_n[1] ? ~dbus_out[47:24] : dbus_out[47:24],
                  dbus_oe_n[0] ? ~dbus_out[23:0] : dbus_out[23:0]};

   // ***************************************************************
   // four-phase transfer
   // ***************************************************************
   task automatic xfer(input logic wr, input logic dbl, input logic [19:0] a, input logic [47:0] wd,
                       input int lim, output logic [47:0] rd, output logic [1:0] oe,
                       output logic e, output int lat, output logic ok);
      @(negedge core_clk);
      q = '{req: 1'b1, wr: wr, dbl: dbl, addr: a, wdata: wd};
      lat = 0;
      // wait, held, until ack or the cycle limit lim
      while (bus_ack !== 1'b1 && lat < lim) begin
         @(negedge core_clk);
         lat++;
      end
      ok = (bus_ack === 1'b1);
      rd = view;
      oe = dbus_oe_n;
      e = parity_err;
      // release, and scramble what is no longer qualified
      q = '{req: 1'b0, wr: ~wr, dbl: ~dbl, addr: ~a, wdata: ~wd};
      while (bus_ack !== 1'b0) begin
         @(negedge core_clk);
      end
   endtask : xfer
endmodule : pwm_bus_master
`default_nettype wire

// ===== dv/pwm_paired_word_memory_tb_top.sv
/*
 * self-checking bench for the paired word memory board.
 * assumes the design, pwm_pkg and the master model; short sim counts.
 */
`timescale 1ns/1ns
`default_nettype none
`include "pwm_regs.svh"

module pwm_paired_word_memory_tb_top import pwm_pkg::*;;
   // ***************************************************************
   // signals
   // ***************************************************************
   logic core_clk = 1'b0, rst = 1'b1, pwr_fail = 1'b0, backup_present = 1'b0;
   logic bus_req, bus_wr, bus_dbl, bus_ack, parity_err, busy;
   logic [19:0] bus_addr;
   logic [47:0] dbus_in, dbus_out, rd;
   logic [1:0] dbus_oe_n, oe;
   logic refresh_mode, refresh_tick, data_lost, e, ok;
   int n_errors = 0, n_checks = 0, lat, ticks = 0;
   logic [19:0] ra[4] = '{20'h00010, 20'h00011, 20'h00020, 20'h00021};
   logic [23:0] rw[4] = '{24'h1a2b3c, 24'h4d5e6f, 24'h778899, 24'haabbcc};

   // ***************************************************************
   // clock, design and master
   // ***************************************************************
   initial forever #5 core_clk = ~core_clk;
   pwm_paired_word_memory #(.REFRESH_CYC(8), .SEC_CYC(10), .HOLD_SEC(3)) dut_u (
      .core_clk(core_clk), .rst(rst), .bus_req(bus_req), .bus_wr(bus_wr), .bus_dbl(bus_dbl),
      .bus_addr(bus_addr), .dbus_in(dbus_in), .dbus_out(dbus_out), .dbus_oe_n(dbus_oe_n),
      .bus_ack(bus_ack), .parity_err(parity_err), .busy(busy), .pwr_fail(pwr_fail),
      .backup_present(backup_present), .refresh_mode(refresh_mode),
      .refresh_tick(refresh_tick), .data_lost(data_lost));
   pwm_bus_master m_u (
      .core_clk(core_clk), .bus_req(bus_req), .bus_wr(bus_wr), .bus_dbl(bus_dbl),
      .bus_addr(bus_addr), .dbus_in(dbus_in), .dbus_out(dbus_out), .dbus_oe_n(dbus_oe_n),
      .bus_ack(bus_ack), .parity_err(parity_err));
   // count refresh pulses
   always @(posedge core_clk) begin
      if (refresh_tick === 1'b1) ticks <= ticks + 1;
   end

   // ***************************************************************
   // helpers
   // ***************************************************************
   task automatic chk(input string nm, input logic [47:0] s, input logic [47:0] x);
      n_checks++;
      if (s !== x) begin
         n_errors++;
         $display("MISMATCH %s expected %h seen %h", nm, x, s);
      end
   endtask : chk
   task automatic end_of_test();
      $display("checks %0d errors %0d", n_checks, n_errors);
      if (n_errors == 0 && n_checks > 0) $display("verification passed");
      else $display("verification failed");
      $finish;
   endtask : end_of_test
   task automatic do_reset();
      rst = 1'b1;
      repeat (20) @(negedge core_clk);
      rst = 1'b0;
   endtask : do_reset
   task automatic wr(input logic dbl, input logic [19:0] a, input logic [47:0] d);
      m_u.xfer(1'b1, dbl, a, d, 100, rd, oe, e, lat, ok);
      chk("wr_ack", {47'h0, ok}, 48'h1);
      chk("wr_oe", {46'h0, oe}, {46'h0, `PWM_OE_OFF});
   endtask : wr
   task automatic rdx(input logic dbl, input logic [19:0] a, input logic [47:0] x, input logic hit);
      // latency is timed from an idle board, so let the last cycle run out first
      while (busy !== 1'b0) @(negedge core_clk);
      m_u.xfer(1'b0, dbl, a, 48'h0, 100, rd, oe, e, lat, ok);
      chk("rd_data", dbl ? rd : {24'h0, rd[23:0]}, x);
      chk("rd_oe", {46'h0, oe}, {46'h0, dbl ? `PWM_OE_DBL : `PWM_OE_SGL});
      chk("rd_err", {47'h0, e}, 48'h0);
      if (hit) chk("hit_lat", {47'h0, lat >= 4 && lat <= 9}, 48'h1);
      else chk("miss_lat", {47'h0, lat >= 29 && lat <= 36}, 48'h1);
   endtask : rdx

   // ***************************************************************
   // tests
   // ***************************************************************
   initial begin
      do_reset();
      chk("rst_oe", {46'h0, dbus_oe_n}, 48'h3);
      chk("rst_out", {dbus_out[47:1], bus_ack}, 48'h0);
      // write reloads the buffer, so the read back is a hit
      wr(1'b1, ra[0], {rw[0], rw[1]});
      rdx(1'b1, ra[0], {rw[0], rw[1]}, 1'b1);
      // double write at an odd address still fills its pair
      wr(1'b1, ra[3], {rw[2], rw[3]});
      for (int i = 0; i < 4; i++) begin
         rdx(1'b0, ra[i], {24'h0, rw[i]}, i[0]);
         if (!i[0]) chk("busy", {47'h0, busy}, 48'h1);
      end
      // single writes keep the partner word
      wr(1'b0, ra[1], {24'hffffff, rw[3]});
      rdx(1'b1, ra[0], {rw[0], rw[3]}, 1'b1);
      wr(1'b0, ra[2], {24'h0, rw[1]});
      rdx(1'b1, ra[3], {rw[1], rw[3]}, 1'b1);
      rdx(1'b1, ra[1], {rw[0], rw[3]}, 1'b0);
      // request raised while that cycle still runs: held, then served
      wr(1'b1, ra[1], {rw[0], rw[3]});
      chk("held_lat", {47'h0, lat > 33 && lat < 45}, 48'h1);
      // another board's address draws no answer
      m_u.xfer(1'b0, 1'b1, 20'h10010, 48'h0, 60, rd, oe, e, lat, ok);
      chk("offboard", {47'h0, ok}, 48'h0);
      // short power fail with backup: refresh only, data kept
      ticks = 0;
      pwr_fail = 1'b1;
      backup_present = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("rf_mode", {47'h0, refresh_mode}, 48'h1);
      m_u.xfer(1'b0, 1'b1, ra[0], 48'h0, 12, rd, oe, e, lat, ok);
      chk("rf_noack", {47'h0, ok}, 48'h0);
      pwr_fail = 1'b0;
      repeat (4) @(negedge core_clk);
      chk("rf_off", {46'h0, refresh_mode, data_lost}, 48'h0);
      chk("rf_ticks", {47'h0, ticks >= 1 && ticks <= 3}, 48'h1);
      m_u.xfer(1'b0, 1'b1, ra[0], 48'h0, 100, rd, oe, e, lat, ok);
      chk("rf_keep", rd, {rw[0], rw[3]});
      // long fail runs the hold time out
      pwr_fail = 1'b1;
      repeat (50) @(negedge core_clk);
      chk("hold_out", {47'h0, data_lost}, 48'h1);
      pwr_fail = 1'b0;
      do_reset();
      chk("lost_clr", {47'h0, data_lost}, 48'h0);
      // fail without backup loses the data, no refresh mode
      backup_present = 1'b0;
      pwr_fail = 1'b1;
      repeat (6) @(negedge core_clk);
      chk("no_backup", {46'h0, data_lost, refresh_mode}, 48'h2);
      end_of_test();
   end
   // watchdog
   initial begin
      #100000;
      n_errors++;
      end_of_test();
   end
endmodule : pwm_paired_word_memory_tb_top
`default_nettype wire
